// ==== src/ppm_pin_mux.sv ====
`timescale 1ns/100ps
`default_nettype none

module ppm_pin_mux (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire ppm_pkg::ppm_ser_t ser0,
  input wire ppm_pkg::ppm_ser_t ser1,
  input wire ppm_pkg::ppm_tmr_t tmr1,
  input wire ppm_pkg::ppm_tmr_t tmr3,
  input wire ppm_pkg::ppm_tmr_t tmr4,
  input wire ppm_pkg::ppm_aud_t aud,
  input wire ppm_pkg::ppm_dbg_t dbg,
  input wire logic low_freq_osc_select,
  input wire logic [2:0] radio_test_active,
  input wire logic [2:0] radio_test_out,
  input wire logic [20:0] pin_i,
  output logic [20:0] pin_o,
  output logic [20:0] pin_oe_n,
  output logic [20:0] pin_analog,
  output logic [20:0] pin_sync
);
  import ppm_pkg::*;

  // ---------------------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------------------
  logic [7:0] port0_data_q;  // Port 0 output data.
  logic [7:0] port1_data_q;  // Port 1 output data.
  logic [7:0] port2_data_q;  // Port 2 output data.
  logic [7:0] periph_loc_q;  // Location bits of the serial units and timers.
  logic [7:0] analog_input_enable_reg_q;  // Port 0 analog enables.
  logic [7:0] port0_function_select_q;  // Port 0 function select.
  logic [7:0] port1_function_select_q;  // Port 1 function select.
  logic [7:0] port2_function_select_q;  // Port 1 precedence and port 2 select.
  logic [7:0] port0_dir_q;  // Port 0 direction, one is output.
  logic [7:0] port1_dir_q;  // Port 1 direction, one is output.
  logic [7:0] port2_dir_q;  // Port 0 precedence and port 2 direction.
  logic [20:0] sync1_q;  // First synchroniser stage.
  logic [7:0] rdata_d;  // Read data selected by address.

  // Writes land on the addressed register; unmapped writes are dropped.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port0_data_q <= RST_PORT_DATA;
      port1_data_q <= RST_PORT_DATA;
      port2_data_q <= RST_PORT_DATA;
      periph_loc_q <= RST_CFG;
      analog_input_enable_reg_q <= RST_CFG;
      port0_function_select_q <= RST_CFG;
      port1_function_select_q <= RST_CFG;
      port2_function_select_q <= RST_CFG;
      port0_dir_q <= RST_CFG;
      port1_dir_q <= RST_CFG;
      port2_dir_q <= RST_CFG;
    end else if (sfr_we) begin
      case (sfr_addr)
        ADDR_PORT0_DATA: port0_data_q <= sfr_wdata;
        ADDR_PORT1_DATA: port1_data_q <= sfr_wdata;
        ADDR_PORT2_DATA: port2_data_q <= sfr_wdata;
        ADDR_PERIPH_LOC: periph_loc_q <= sfr_wdata & MASK_PERIPH_LOC;
        ADDR_ANALOG_EN: analog_input_enable_reg_q <= sfr_wdata;
        ADDR_PORT0_SEL: port0_function_select_q <= sfr_wdata;
        ADDR_PORT1_SEL: port1_function_select_q <= sfr_wdata;
        ADDR_PORT2_SEL: port2_function_select_q <= sfr_wdata & MASK_PORT2_SEL;
        ADDR_PORT0_DIR: port0_dir_q <= sfr_wdata;
        ADDR_PORT1_DIR: port1_dir_q <= sfr_wdata;
        ADDR_PORT2_DIR: port2_dir_q <= sfr_wdata & MASK_PORT2_DIR;
        default: begin
        end
      endcase
    end
  end

  // Data addresses read the synchronised pin levels, port 2 bits 7:5 the register; other mapped addresses read the register.
  always_comb begin
    case (sfr_addr)
      ADDR_PORT0_DATA: rdata_d = pin_sync[7:0];
      ADDR_PORT1_DATA: rdata_d = pin_sync[15:8];
      ADDR_PORT2_DATA: rdata_d = {port2_data_q[7:5], pin_sync[20:16]};
      ADDR_PERIPH_LOC: rdata_d = periph_loc_q;
      ADDR_ANALOG_EN: rdata_d = analog_input_enable_reg_q;
      ADDR_PORT0_SEL: rdata_d = port0_function_select_q;
      ADDR_PORT1_SEL: rdata_d = port1_function_select_q;
      ADDR_PORT2_SEL: rdata_d = port2_function_select_q;
      ADDR_PORT0_DIR: rdata_d = port0_dir_q;
      ADDR_PORT1_DIR: rdata_d = port1_dir_q;
      ADDR_PORT2_DIR: rdata_d = port2_dir_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data is captured on a read strobe and held until the next one.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_re) begin
      sfr_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin input synchroniser.
  // ---------------------------------------------------------------------------
  // Two stages guard against metastability from asynchronous pin levels.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      pin_sync <= '0;
    end else begin
      sync1_q <= pin_i;
      pin_sync <= sync1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Placement of peripheral signals onto pins.
  // ---------------------------------------------------------------------------
  // Spreads up to four role signals onto the pins named by the index table.
  function automatic ppm_pinset_t place(input logic [3:0][4:0] idx, input logic [3:0] use_m,
                                        input logic [3:0] out, input logic [3:0] oe);
    ppm_pinset_t r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      if (use_m[k]) begin
        r.claim[idx[k]] = 1'b1;
        r.out[idx[k]] = out[k];
        r.oe[idx[k]] = oe[k];
      end
    end
    return r;
  endfunction : place

  ppm_pinset_t set_s0;  // Serial unit 0 placement.
  ppm_pinset_t set_s1;  // Serial unit 1 placement.
  ppm_pinset_t set_t1;  // Timer 1 placement.
  ppm_pinset_t set_t3;  // Timer 3 placement.
  ppm_pinset_t set_t4;  // Timer 4 placement.
  ppm_pinset_t set_au;  // Audio serial placement.
  logic [3:0] s0_use;  // Serial 0 roles that claim pins.
  logic [3:0] s1_use;  // Serial 1 roles that claim pins.

  // A flowless asynchronous serial unit leaves its flow-control pins alone.
  assign s0_use = ser0.uart_noflow ? 4'h3 : 4'hF;
  assign s1_use = ser1.uart_noflow ? 4'h3 : 4'hF;

  // Each location bit chooses the first set at zero and the second at one.
  assign set_s0 = place(periph_loc_q[LOC_SER0] ? SER0_ALT2 : SER0_ALT1, s0_use, ser0.out, ser0.oe);
  assign set_s1 = place(periph_loc_q[LOC_SER1] ? SER1_ALT2 : SER1_ALT1, s1_use, ser1.out, ser1.oe);
  assign set_t1 = place(periph_loc_q[LOC_TMR1] ? TMR1_ALT2 : TMR1_ALT1, 4'h7,
                        {1'b0, tmr1.out}, {1'b0, tmr1.oe});
  assign set_t3 = place(periph_loc_q[LOC_TMR3] ? TMR3_ALT2 : TMR3_ALT1, 4'h3,
                        {1'b0, tmr3.out}, {1'b0, tmr3.oe});
  assign set_t4 = place(periph_loc_q[LOC_TMR4] ? TMR4_ALT2 : TMR4_ALT1, 4'h3,
                        {1'b0, tmr4.out}, {1'b0, tmr4.oe});
  assign set_au = place(aud.audio_serial_location_bit ? AUD_ALT2 : AUD_ALT1, {4{aud.audio_serial_enable}},
                        aud.out, aud.oe);

  // ---------------------------------------------------------------------------
  // Precedence between peripherals.
  // ---------------------------------------------------------------------------
  // Candidate order: 0 serial 0, 1 serial 1, 2 timer 1, 3 timer 3, 4 timer 4.
  logic [NUM_CAND-1:0][NUM_CAND-1:0] beat0;  // Port 0: row beats column.
  logic [NUM_CAND-1:0][NUM_CAND-1:0] beat1;  // Port 1 and port 2.
  logic [1:0] port0_precedence_field;  // Port 0 precedence field.

  assign port0_precedence_field = port2_dir_q[PREC0_LSB +: 2];

  // Pairs that no precedence control covers fall back to candidate order.
  always_comb begin
    for (int x = 0; x < NUM_CAND; x++) begin
      for (int y = 0; y < NUM_CAND; y++) begin
        beat0[x][y] = (x < y);
        beat1[x][y] = (x < y);
      end
    end
    case (port0_precedence_field)
      2'b00: begin
        beat0[0][1] = 1'b1;
        beat0[1][0] = 1'b0;
      end
      2'b01: begin
        beat0[1][0] = 1'b1;
        beat0[0][1] = 1'b0;
      end
      2'b10: begin
        beat0[2][1] = 1'b1;
        beat0[1][2] = 1'b0;
      end
      default: begin
        beat0[2][0] = 1'b1;
        beat0[0][2] = 1'b0;
      end
    endcase
    // Serial 0 against serial 1.
    beat1[1][0] = port2_function_select_q[PREC1_B3];
    beat1[0][1] = !port2_function_select_q[PREC1_B3];
    // Serial 1 against timer 3.
    beat1[3][1] = port2_function_select_q[PREC1_B2];
    beat1[1][3] = !port2_function_select_q[PREC1_B2];
    // Timer 1 against timer 4.
    beat1[4][2] = port2_function_select_q[PREC1_B1];
    beat1[2][4] = !port2_function_select_q[PREC1_B1];
    // Serial 0 against timer 1.
    beat1[2][0] = port2_function_select_q[PREC1_B0];
    beat1[0][2] = !port2_function_select_q[PREC1_B0];
  end

  // Picks the first claimer that beats every other claimer; an inconclusive
  // set, which software must avoid, falls back to the first claimer.
  function automatic logic [NUM_CAND-1:0] pick(input logic [NUM_CAND-1:0] c,
                                               input logic [NUM_CAND-1:0][NUM_CAND-1:0] b);
    logic [NUM_CAND-1:0] win;
    logic found;
    logic ok;
    win = '0;
    found = 1'b0;
    for (int x = 0; x < NUM_CAND; x++) begin
      ok = c[x];
      for (int y = 0; y < NUM_CAND; y++) begin
        if (y != x && c[y] && !b[x][y]) begin
          ok = 1'b0;
        end
      end
      if (ok && !found) begin
        win[x] = 1'b1;
        found = 1'b1;
      end
    end
    for (int x = 0; x < NUM_CAND; x++) begin
      if (!found && c[x]) begin
        win[x] = 1'b1;
        found = 1'b1;
      end
    end
    return win;
  endfunction : pick

  // ---------------------------------------------------------------------------
  // Per-pin ownership and drive.
  // ---------------------------------------------------------------------------
  logic [20:0] fsel;  // Function select per pin.
  logic [20:0] gpio_out;  // General I/O data per pin.
  logic [20:0] gpio_dir;  // General I/O direction per pin.
  logic [20:0] analog_en;  // Analog enable per port 0 pin.

  assign fsel = {port2_function_select_q[2:1], 2'b00, port2_function_select_q[0],
                 port1_function_select_q, port0_function_select_q};
  assign gpio_out = {port2_data_q[4:0], port1_data_q, port0_data_q};
  assign gpio_dir = {port2_dir_q[4:0], port1_dir_q, port0_dir_q};
  assign analog_en = {13'h0000, analog_input_enable_reg_q};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic [NUM_CAND-1:0] claims;  // Peripherals claiming this pin.
      logic [NUM_CAND-1:0] win;  // One-hot winner.
      logic o_d;  // Next pin value.
      logic drv_d;  // Next drive state.
      logic ana_d;  // Next analog state.
      logic xtal;  // Crystal pin in analog mode.
      logic rtest;  // Radio test output owns the pin.
      logic rt_val;  // Radio test value for this pin, zero where none exists.

      assign claims = {set_t4.claim[gi], set_t3.claim[gi], set_t1.claim[gi], set_s1.claim[gi], set_s0.claim[gi]};
      assign win = pick(claims, (gi < 8) ? beat0 : beat1);
      assign xtal = (gi == PIN_XTAL_LO || gi == PIN_XTAL_HI) && !low_freq_osc_select;
      if (gi >= PIN_RTEST_LO && gi < PIN_RTEST_LO + 3) begin : g_rt
        assign rtest = radio_test_active[gi-PIN_RTEST_LO] && !aud.audio_serial_enable;
        assign rt_val = radio_test_out[gi-PIN_RTEST_LO];
      end else begin : g_nrt
        // Pins outside the test range never index the test bus.
        assign rtest = 1'b0;
        assign rt_val = 1'b0;
      end

      // Owner order: analog, debug, audio, radio test, peripheral, general I/O.
      always_comb begin
        o_d = gpio_out[gi];
        drv_d = gpio_dir[gi];
        ana_d = 1'b0;
        if (xtal || analog_en[gi]) begin
          ana_d = 1'b1;
          drv_d = 1'b0;
        end else if (dbg.active && (gi == PIN_DBG_DATA || gi == PIN_DBG_CLK)) begin
          o_d = dbg.dd_out;
          drv_d = (gi == PIN_DBG_DATA) && dbg.dd_drive;
        end else if (set_au.claim[gi]) begin
          o_d = set_au.out[gi];
          drv_d = set_au.oe[gi];
        end else if (rtest) begin
          o_d = rt_val;
          drv_d = 1'b1;
        end else if (fsel[gi] && |claims) begin
          drv_d = 1'b0;
          for (int k = 0; k < NUM_CAND; k++) begin
            if (win[k]) begin
              o_d = (k == 0) ? set_s0.out[gi] : (k == 1) ? set_s1.out[gi] : (k == 2) ? set_t1.out[gi] :
                    (k == 3) ? set_t3.out[gi] : set_t4.out[gi];
              drv_d = (k == 0) ? set_s0.oe[gi] : (k == 1) ? set_s1.oe[gi] : (k == 2) ? set_t1.oe[gi] :
                      (k == 3) ? set_t3.oe[gi] : set_t4.oe[gi];
            end
          end
        end
      end

      // Pin outputs are registered; the enable is low while driving.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_o[gi] <= 1'b1;
          pin_oe_n[gi] <= 1'b1;
          pin_analog[gi] <= 1'b0;
        end else begin
          pin_o[gi] <= o_d;
          pin_oe_n[gi] <= !drv_d;
          pin_analog[gi] <= ana_d;
        end
      end
    end
  endgenerate

endmodule : ppm_pin_mux

`default_nettype wire

// ==== src/ppm_pkg.sv ====
package ppm_pkg;

  // ---------------------------------------------------------------------------
  // Special function register addresses.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;  // Port 0 data.
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;  // Port 1 data.
  localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;  // Port 2 data.
  localparam logic [7:0] ADDR_PERIPH_LOC = 8'hF1;  // Peripheral location bits.
  localparam logic [7:0] ADDR_ANALOG_EN = 8'hF2;  // Analog-input enables.
  localparam logic [7:0] ADDR_PORT0_SEL = 8'hF3;  // Port 0 function select.
  localparam logic [7:0] ADDR_PORT1_SEL = 8'hF4;  // Port 1 function select.
  localparam logic [7:0] ADDR_PORT2_SEL = 8'hF5;  // Port 1 precedence and port 2 select.
  localparam logic [7:0] ADDR_PORT0_DIR = 8'hFD;  // Port 0 direction.
  localparam logic [7:0] ADDR_PORT1_DIR = 8'hFE;  // Port 1 direction.
  localparam logic [7:0] ADDR_PORT2_DIR = 8'hFF;  // Port 0 precedence and port 2 direction.

  // ---------------------------------------------------------------------------
  // Reset values and writable masks.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_PORT_DATA = 8'hFF;  // Data registers reset high.
  localparam logic [7:0] RST_CFG = 8'h00;  // Configuration registers reset low.
  localparam logic [7:0] MASK_PERIPH_LOC = 8'h73;  // Bits 7 and 3:2 read as zero.
  localparam logic [7:0] MASK_PORT2_SEL = 8'h7F;  // Bit 7 reads as zero.
  localparam logic [7:0] MASK_PORT2_DIR = 8'hDF;  // Bit 5 reads as zero.

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int LOC_SER0 = 0;  // Serial unit 0 location bit.
  localparam int LOC_SER1 = 1;  // Serial unit 1 location bit.
  localparam int LOC_TMR4 = 4;  // Timer 4 location bit.
  localparam int LOC_TMR3 = 5;  // Timer 3 location bit.
  localparam int LOC_TMR1 = 6;  // Timer 1 location bit.
  localparam int PREC1_B0 = 3;  // Serial 0 against timer 1 on port 1.
  localparam int PREC1_B1 = 4;  // Timer 1 against timer 4 on port 1.
  localparam int PREC1_B2 = 5;  // Serial 1 against timer 3 on port 1.
  localparam int PREC1_B3 = 6;  // Serial 0 against serial 1 on port 1.
  localparam int PREC0_LSB = 6;  // Low bit of the port 0 precedence field.

  // ---------------------------------------------------------------------------
  // Pin numbering: port 0 at 0..7, port 1 at 8..15, port 2 at 16..20.
  // ---------------------------------------------------------------------------
  localparam int NUM_PINS = 21;  // Total pins handled.
  localparam int NUM_CAND = 5;  // Arbitrated peripherals.

  // Pin indices, role 3 down to role 0 (cts/ssn, rts/sck, tx/mosi, rx/miso).
  localparam logic [3:0][4:0] SER0_ALT1 = {5'h04, 5'h05, 5'h03, 5'h02};  // Serial 0 first set.
  localparam logic [3:0][4:0] SER0_ALT2 = {5'h0A, 5'h0B, 5'h0D, 5'h0C};  // Serial 0 second set.
  localparam logic [3:0][4:0] SER1_ALT1 = {5'h02, 5'h03, 5'h04, 5'h05};  // Serial 1 first set.
  localparam logic [3:0][4:0] SER1_ALT2 = {5'h0C, 5'h0D, 5'h0E, 5'h0F};  // Serial 1 second set.
  // Timer channels, channel 3 slot unused, then channels 2, 1, 0.
  localparam logic [3:0][4:0] TMR1_ALT1 = {5'h00, 5'h04, 5'h03, 5'h02};  // Timer 1 first set.
  localparam logic [3:0][4:0] TMR1_ALT2 = {5'h00, 5'h08, 5'h09, 5'h0A};  // Timer 1 second set.
  localparam logic [3:0][4:0] TMR3_ALT1 = {5'h00, 5'h00, 5'h0C, 5'h0B};  // Timer 3 first set.
  localparam logic [3:0][4:0] TMR3_ALT2 = {5'h00, 5'h00, 5'h0F, 5'h0E};  // Timer 3 second set.
  localparam logic [3:0][4:0] TMR4_ALT1 = {5'h00, 5'h00, 5'h09, 5'h08};  // Timer 4 first set.
  localparam logic [3:0][4:0] TMR4_ALT2 = {5'h00, 5'h00, 5'h13, 5'h10};  // Timer 4 second set.
  // Audio roles: data out, data in, word select, clock.
  localparam logic [3:0][4:0] AUD_ALT1 = {5'h0E, 5'h0F, 5'h00, 5'h01};  // Audio first set.
  localparam logic [3:0][4:0] AUD_ALT2 = {5'h10, 5'h11, 5'h12, 5'h13};  // Audio second set.
  localparam int PIN_DBG_DATA = 17;  // Debug data pin.
  localparam int PIN_DBG_CLK = 18;  // Debug clock pin.
  localparam int PIN_XTAL_LO = 19;  // First crystal pin.
  localparam int PIN_XTAL_HI = 20;  // Second crystal pin.
  localparam int PIN_RTEST_LO = 13;  // Lowest radio test pin.

  // ---------------------------------------------------------------------------
  // Signal groups.
  // ---------------------------------------------------------------------------
  // Serial unit pins by role, with its no-flow-control asynchronous flag.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic uart_noflow;
  } ppm_ser_t;

  // Timer channel pins, up to three channels.
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } ppm_tmr_t;

  // Audio serial pins with its enable and location bit.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic audio_serial_enable;
    logic audio_serial_location_bit;
  } ppm_aud_t;

  // Debug interface state.
  typedef struct packed {
    logic active;
    logic dd_drive;
    logic dd_out;
  } ppm_dbg_t;

  // Per-pin claim, value and drive produced by one peripheral.
  typedef struct packed {
    logic [NUM_PINS-1:0] claim;
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } ppm_pinset_t;

endpackage : ppm_pkg

// ==== sim/ppm_pin_mux_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// Watches pin ownership at the top ports; relations are one registered stage deep, the synchroniser check two.
module ppm_pin_mux_monitor
  import ppm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  input wire ppm_pkg::ppm_aud_t aud,
  input wire ppm_pkg::ppm_dbg_t dbg,
  input wire logic low_freq_osc_select,
  input wire logic [2:0] radio_test_active,
  input wire logic [2:0] radio_test_out,
  input wire logic [20:0] pin_i,
  input wire logic [20:0] pin_o,
  input wire logic [20:0] pin_oe_n,
  input wire logic [20:0] pin_analog,
  input wire logic [20:0] pin_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Two edges out of reset, so both synchroniser stages hold real samples.
  sequence s_run2;
    !sys_rst ##1 !sys_rst;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> (&pin_oe_n) && (&pin_o) && (pin_analog == '0))
    else $error("pins not idle in reset");
  a_crystal_analog: assert property (!low_freq_osc_select |=> pin_analog[19] && pin_analog[20])
    else $error("crystal pins not analog");
  a_dbg_clk_in: assert property (dbg.active |=> pin_oe_n[18])
    else $error("debug clock pin driven");
  a_dbg_data_out: assert property (dbg.active && dbg.dd_drive |=> !pin_oe_n[17] && pin_o[17] == $past(dbg.dd_out))
    else $error("debug data pin wrong");
  a_aud_second_set: assert property (aud.audio_serial_enable && aud.audio_serial_location_bit && aud.oe[3]
    |=> !pin_oe_n[16] && pin_o[16] == $past(aud.out[3]))
    else $error("audio data out not on second set");
  a_aud_over_radio: assert property (aud.audio_serial_enable && !aud.audio_serial_location_bit && aud.oe[3]
    && radio_test_active[1] |=> !pin_oe_n[14] && pin_o[14] == $past(aud.out[3]))
    else $error("audio lost pin to radio test");
  a_radio_drive: assert property (radio_test_active[0] && !aud.audio_serial_enable
    |=> !pin_oe_n[13] && pin_o[13] == $past(radio_test_out[0]))
    else $error("radio test pin wrong");
  a_sync_two: assert property (s_run2 |=> pin_sync == $past(pin_i, 2))
    else $error("pin sync delay wrong");
  a_unmapped_zero: assert property (sfr_re && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_loc_masked: assert property (sfr_re && sfr_addr == ADDR_PERIPH_LOC |=> sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'h0)
    else $error("unused location bits read high");
endmodule : ppm_pin_mux_monitor
`default_nettype wire

// ==== sim/ppm_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Pads: a driven pin reads back its value, a released one floats to its pull-up.
// Port 1 bits 0 and 1 have no pull, so released they wander every cycle.
module ppm_pin_model (
  input wire logic clk,
  input wire logic [20:0] pin_o,
  input wire logic [20:0] pin_oe_n,
  output logic [20:0] pin_i
);
  logic wander_q = 1'b0;  // Level of the unpulled pins.
  always_ff @(posedge clk) wander_q <= ~wander_q;
  assign pin_i = (pin_o & ~pin_oe_n) | (pin_oe_n & {11'h7FF, {2{wander_q}}, 8'hFF});
endmodule : ppm_pin_model
`default_nettype wire

// ==== sim/ppm_pin_mux_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module ppm_pin_mux_tb;
  import ppm_pkg::*;
  typedef struct packed {logic [1:0] k; logic [4:0] i; logic [7:0] e;} ppm_note_t;  // Kind, pin, expected.
  logic clk = 0, sys_rst = 1, sfr_we = 0, sfr_re = 0, low_freq_osc_select = 0, obs = 0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, got, r;
  logic [2:0] radio_test_active = '0, radio_test_out = '0;
  logic [20:0] pin_i, pin_o, pin_oe_n, pin_analog, pin_sync;
  ppm_ser_t ser0 = '0, ser1 = '0;
  ppm_tmr_t tmr1 = '0, tmr3 = '0, tmr4 = '0;
  ppm_aud_t aud = '0;
  ppm_dbg_t dbg = '0;
  int error_cnt = 0, check_count = 0, tn = 0;
  ppm_note_t q[$], n;
  logic [7:0] ra [6] = '{ADDR_PERIPH_LOC, ADDR_ANALOG_EN, ADDR_PORT0_SEL, ADDR_PORT2_DIR, 8'h00, ADDR_PORT0_DATA};
  logic [7:0] wa [8] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hFD, 8'hFE, 8'hFF};
  logic [7:0] wm [8] = '{8'h73, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hDF};
  logic [7:0] ca [6] = '{ADDR_PERIPH_LOC, ADDR_ANALOG_EN, ADDR_PORT0_SEL, ADDR_PORT1_SEL, ADDR_PORT2_SEL, ADDR_PORT2_DIR};
  always #25 clk = ~clk;
  ppm_pin_mux dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ser0(ser0), .ser1(ser1), .tmr1(tmr1), .tmr3(tmr3), .tmr4(tmr4),
    .aud(aud), .dbg(dbg), .low_freq_osc_select(low_freq_osc_select), .radio_test_active(radio_test_active),
    .radio_test_out(radio_test_out), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_analog(pin_analog),
    .pin_sync(pin_sync));
  ppm_pin_model u_pins (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i));
  // One register write; the strobe drops for a cycle before the next one.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge clk) sfr_we <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Files an expectation and flags the watcher to take it at the next edge.
  task automatic note(int k, int i, logic [7:0] e);
    q.push_back('{2'(k), 5'(i), e});
    obs <= 1'b1;
    @(posedge clk) obs <= 1'b0;
    @(posedge clk);
  endtask : note
  task automatic rd(logic [7:0] a, logic [7:0] e);
    sfr_addr <= a;
    sfr_re <= 1'b1;
    @(posedge clk) sfr_re <= 1'b0;
    note(0, 0, e);
  endtask : rd
  task automatic cfg(logic [7:0] c [6]);
    foreach (c[j]) wr(ca[j], c[j]);
    repeat (3) @(posedge clk);
  endtask : cfg
  task automatic tend;
    tn++;
    $display("test %0d done", tn);
  endtask : tend
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Watcher: kind 0 read data, 1 pin value, 2 pin drive, 3 analog mode.
  always @(posedge clk) if (obs) begin
    n = q.pop_front();
    case (n.k)
      2'h0: got = sfr_rdata;
      2'h1: got = 8'(pin_o[n.i]);
      2'h2: got = 8'(pin_oe_n[n.i]);
      default: got = 8'(pin_analog[n.i]);
    endcase
    `CHK(got, n.e)
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    r = $urandom(32'h0633_4967);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ra[j]) rd(ra[j], (j == 5) ? 8'hFF : 8'h00);
    tend;
    foreach (wa[j]) begin
      r = $urandom;
      wr(wa[j], r);
      rd(wa[j], r & wm[j]);
    end
    tend;
    ser0 <= '{4'h0, 4'hF, 1'b0};
    for (int l = 0; l < 2; l++) begin
      cfg('{8'(l), 8'h00, 8'h08, 8'h20, 8'h00, 8'h00});
      note(2, l ? 13 : 3, 8'h00);
    end
    tend;
    ser1 <= '{4'hF, 4'hF, 1'b0};
    for (int f = 0; f < 4; f++) begin
      tmr1 <= '{{3{f[0]}}, 3'h7};
      cfg('{(f < 2) ? 8'h40 : 8'(f - 1), 8'h00, 8'h08, 8'h00, 8'h00, 8'(f << 6)});
      note(1, 3, 8'(f[0]));
    end
    ser0.uart_noflow <= 1'b1;
    cfg('{8'h40, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00});
    note(1, 5, 8'h01);
    ser0.uart_noflow <= 1'b0;
    tend;
    tmr1 <= '{3'h0, 3'h7};
    tmr3 <= '{3'h0, 3'h7};
    tmr4 <= '{3'h7, 3'h7};
    for (int b = 0; b < 2; b++) begin
      cfg('{8'h63, 8'h00, 8'h00, 8'h91, b ? 8'h70 : 8'h00, 8'h00});
      note(1, 8, 8'(b));
      note(1, 12, 8'(b));
      note(1, 15, 8'(1 - b));
    end
    tend;
    r = $urandom;
    cfg('{8'h00, r, 8'hFF, 8'h00, 8'h00, 8'h00});
    for (int p = 0; p < 8; p++) note(3, p, 8'(r[p]));
    r = $urandom;
    cfg('{8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00});
    wr(ADDR_PORT0_DIR, 8'hFF);
    wr(ADDR_PORT0_DATA, r);
    repeat (3) @(posedge clk);
    for (int p = 0; p < 8; p++) note(1, p, 8'(r[p]));
    rd(ADDR_PORT0_DATA, r);
    tend;
    repeat (300) begin
      {dbg, aud, radio_test_active, radio_test_out, low_freq_osc_select} <= 20'($urandom);
      @(posedge clk);
    end
    low_freq_osc_select <= 1'b0;
    repeat (3) @(posedge clk);
    note(3, 19, 8'h01);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_ANALOG_EN, 8'h00);
    tend;
    test_done;
  end
endmodule : ppm_pin_mux_tb
bind ppm_pin_mux ppm_pin_mux_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_re(sfr_re),
  .sfr_rdata(sfr_rdata), .aud(aud), .dbg(dbg), .low_freq_osc_select(low_freq_osc_select),
  .radio_test_active(radio_test_active), .radio_test_out(radio_test_out), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n(pin_oe_n), .pin_analog(pin_analog), .pin_sync(pin_sync));
`default_nettype wire
